// [design/sdfd_regs.vh]
// Behaviour
// - Third word carries first operand and flag half; direct four-lane layout applies.
// - Bit 25 picks one of two flag halves, sixteen flags each.
// - With predication on, predicate mask comes from the selected flag half.
// - With condition modifier on, condition flags go to the selected half.
// - One flag half may be predicate source and condition target together.
// - Vertical step is bits 24:21.
// - Bits 19:16 are swizzle bits 7:4.
// - Bit 15 is the addressing kind.
// - Bits 14:13 are the two-bit source modifier.
// - Bits 12:5 are the eight-bit register index.
// - Bit 4 picks upper or lower sixteen-byte half of register.
// - Bits 3:0 are the four lane enables.
// - Immediate first operand makes all operand fields ignored.
`ifndef SDFD_REGS_VH
`define SDFD_REGS_VH
// Field positions in the third instruction word
`define SDFD_MBZ_HI_MSB 31
`define SDFD_MBZ_HI_LSB 26
`define SDFD_FLAG_HALF_BIT 25
`define SDFD_VSTEP_MSB 24
`define SDFD_VSTEP_LSB 21
`define SDFD_MBZ_MID_BIT 20
`define SDFD_SWZ_MSB 19
`define SDFD_SWZ_LSB 16
`define SDFD_ADDR_KIND_BIT 15
`define SDFD_MOD_MSB 14
`define SDFD_MOD_LSB 13
`define SDFD_REG_MSB 12
`define SDFD_REG_LSB 5
`define SDFD_HALF_OFS_BIT 4
`define SDFD_LANE_MSB 3
`define SDFD_LANE_LSB 0
// Flag register shape
`define SDFD_FLAG_HALF_W 16
// AXI4-Lite register byte offsets
`define SDFD_REG_WORD 8'h00
`define SDFD_REG_CTRL 8'h04
`define SDFD_REG_FIELDS 8'h08
`define SDFD_REG_FLAGS 8'h0C
`define SDFD_REG_STATUS 8'h10
// Control bits
`define SDFD_CTRL_PRED_BIT 0
`define SDFD_CTRL_COND_BIT 1
`define SDFD_CTRL_IMM_BIT 2
`define SDFD_CTRL_DIRECT_BIT 3
`define SDFD_CTRL_FOUR_LANE_ALIGNED_ACCESS_BIT 4
// Reset values
`define SDFD_RST_WORD 32'h0000_0000
`define SDFD_RST_CTRL 5'h18
`define SDFD_RST_FLAGS 32'h0000_0000
`endif

// [design/sdfd_field_split.v]
`timescale 1ns/1ps
`include "sdfd_regs.vh"
module sdfd_field_split (
  // Raw word
  input wire [31:0] i_word,
  input wire i_imm,
  // Fields
  output wire o_flag_half_select,
  output wire [3:0] o_vertical_step,
  output wire [7:4] o_swizzle_hi,
  output wire o_addressing_kind,
  output wire [1:0] o_modifier,
  output wire [7:0] o_register_index,
  output wire o_half_offset,
  output wire [3:0] o_lane_enables,
  output wire o_must_be_zero_err
);
  // Flag half always decoded, operand fields masked when immediate
  assign o_flag_half_select = i_word[`SDFD_FLAG_HALF_BIT];
  assign o_vertical_step = i_imm ? 4'h0 :
    i_word[`SDFD_VSTEP_MSB:`SDFD_VSTEP_LSB];
  assign o_swizzle_hi = i_imm ? 4'h0 :
    i_word[`SDFD_SWZ_MSB:`SDFD_SWZ_LSB];
  assign o_addressing_kind = i_imm ? 1'b0 :
    i_word[`SDFD_ADDR_KIND_BIT];
  assign o_modifier = i_imm ? 2'h0 :
    i_word[`SDFD_MOD_MSB:`SDFD_MOD_LSB];
  assign o_register_index = i_imm ? 8'h00 :
    i_word[`SDFD_REG_MSB:`SDFD_REG_LSB];
  assign o_half_offset = i_imm ? 1'b0 :
    i_word[`SDFD_HALF_OFS_BIT];
  assign o_lane_enables = i_imm ? 4'h0 :
    i_word[`SDFD_LANE_MSB:`SDFD_LANE_LSB];
  // Reserved bits seen nonzero
  assign o_must_be_zero_err =
    (|i_word[`SDFD_MBZ_HI_MSB:`SDFD_MBZ_HI_LSB]) |
    i_word[`SDFD_MBZ_MID_BIT];
endmodule // sdfd_field_split

// [design/sdfd_flag_file.v]
`timescale 1ns/1ps
`include "sdfd_regs.vh"
module sdfd_flag_file #(
  parameter FW = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Software write of both halves
  input wire i_sw_we,
  input wire [2*FW-1:0] i_sw_data,
  // Instruction side
  input wire i_sel,
  input wire i_pred_en,
  input wire i_cond_en,
  input wire i_cond_we,
  input wire [FW-1:0] i_cond_flags,
  // Results
  output wire [FW-1:0] o_pred_mask,
  output wire [2*FW-1:0] o_flags
);
  // Per-half storage; condition write beats software write
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_half
      reg [FW-1:0] half_q;
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          half_q <= {FW{1'b0}};
        end else if (i_cond_en && i_cond_we && (i_sel == (g == 1))) begin
          half_q <= i_cond_flags;
        end else if (i_sw_we) begin
          half_q <= i_sw_data[g*FW +: FW];
        end
      end
    end
  endgenerate
  // Predicate read from selected half; all ones when disabled
  assign o_pred_mask = !i_pred_en ? {FW{1'b1}} :
    (i_sel ? g_half[1].half_q : g_half[0].half_q);
  assign o_flags = {g_half[1].half_q, g_half[0].half_q};
endmodule // sdfd_flag_file

// [design/sdfd_top.v]
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sdfd_regs.vh"
module sdfd_top (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Fetch side: third instruction word
  input wire i_word_valid,
  input wire [31:0] i_third_instruction_word,
  input wire i_direct,
  input wire i_four_lane_aligned_access,
  input wire i_src_immediate,
  input wire i_pred_enable,
  input wire i_cond_enable,
  // Condition result from execution
  input wire i_cond_we,
  input wire [15:0] i_cond_flags,
  // Decoded outputs
  output reg o_fields_valid,
  output reg o_flag_half_select,
  output reg [3:0] o_first_operand_vertical_step,
  output reg [7:4] o_first_operand_swizzle,
  output reg o_first_operand_addressing_kind,
  output reg [1:0] o_first_operand_modifier,
  output reg [7:0] o_first_operand_register_index,
  output reg o_first_operand_half_offset,
  output reg [3:0] o_first_operand_lane_enables,
  output reg o_must_be_zero_err,
  output wire [15:0] o_pred_mask,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  //////////////////////////////////////////////////////////////////////////
  // Software registers
  reg [31:0] sw_word_q;
  reg [4:0] ctrl_q;
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;
  reg sw_kick_q;
  wire wr_go;
  wire flag_we;
  wire [31:0] flag_wdata;
  wire [31:0] flags_all;

  //////////////////////////////////////////////////////////////////////////
  // Word source: fetch pipe, or software word when kicked
  wire use_sw = sw_kick_q;
  wire [31:0] word = use_sw ? sw_word_q : i_third_instruction_word;
  wire direct = use_sw ? ctrl_q[`SDFD_CTRL_DIRECT_BIT] : i_direct;
  wire four_lane_aligned_access = use_sw ? ctrl_q[`SDFD_CTRL_FOUR_LANE_ALIGNED_ACCESS_BIT] :
    i_four_lane_aligned_access;
  wire imm = use_sw ? ctrl_q[`SDFD_CTRL_IMM_BIT] : i_src_immediate;
  wire pred_en = ctrl_q[`SDFD_CTRL_PRED_BIT] | i_pred_enable;
  wire cond_en = ctrl_q[`SDFD_CTRL_COND_BIT] | i_cond_enable;
  // Layout applies only to direct four-lane form
  wire layout_ok = direct & four_lane_aligned_access;
  wire take = (i_word_valid | use_sw) & layout_ok;

  wire f_flag;
  wire [3:0] f_vstep;
  wire [7:4] f_swz;
  wire f_kind;
  wire [1:0] f_mod;
  wire [7:0] f_reg;
  wire f_half;
  wire [3:0] f_lane;
  wire f_err;

  // Field extraction
  sdfd_field_split u_split (
    .i_word(word),
    .i_imm(imm),
    .o_flag_half_select(f_flag),
    .o_vertical_step(f_vstep),
    .o_swizzle_hi(f_swz),
    .o_addressing_kind(f_kind),
    .o_modifier(f_mod),
    .o_register_index(f_reg),
    .o_half_offset(f_half),
    .o_lane_enables(f_lane),
    .o_must_be_zero_err(f_err)
  );

  // Registered parallel field outputs
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fields_valid <= 1'b0;
      o_flag_half_select <= 1'b0;
      o_first_operand_vertical_step <= 4'h0;
      o_first_operand_swizzle <= 4'h0;
      o_first_operand_addressing_kind <= 1'b0;
      o_first_operand_modifier <= 2'h0;
      o_first_operand_register_index <= 8'h00;
      o_first_operand_half_offset <= 1'b0;
      o_first_operand_lane_enables <= 4'h0;
      o_must_be_zero_err <= 1'b0;
    end else begin
      o_fields_valid <= take;
      if (take) begin
        o_flag_half_select <= f_flag;
        o_first_operand_vertical_step <= f_vstep;
        o_first_operand_swizzle <= f_swz;
        o_first_operand_addressing_kind <= f_kind;
        o_first_operand_modifier <= f_mod;
        o_first_operand_register_index <= f_reg;
        o_first_operand_half_offset <= f_half;
        o_first_operand_lane_enables <= f_lane;
        o_must_be_zero_err <= f_err;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flag register with predicate read and condition write
  sdfd_flag_file #(
    .FW(`SDFD_FLAG_HALF_W)
  ) u_flags (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sw_we(flag_we),
    .i_sw_data(flag_wdata),
    .i_sel(o_flag_half_select),
    .i_pred_en(pred_en),
    .i_cond_en(cond_en),
    .i_cond_we(i_cond_we),
    .i_cond_flags(i_cond_flags),
    .o_pred_mask(o_pred_mask),
    .o_flags(flags_all)
  );

  //////////////////////////////////////////////////////////////////////////
  // AXI write: accept address and data in either order
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign flag_we = wr_go && (awaddr_q == `SDFD_REG_FLAGS);
  assign flag_wdata = {
    wstrb_q[3] ? wdata_q[31:24] : flags_all[31:24],
    wstrb_q[2] ? wdata_q[23:16] : flags_all[23:16],
    wstrb_q[1] ? wdata_q[15:8] : flags_all[15:8],
    wstrb_q[0] ? wdata_q[7:0] : flags_all[7:0]};

  // Write channel capture and register update
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      sw_word_q <= `SDFD_RST_WORD;
      ctrl_q <= `SDFD_RST_CTRL;
      sw_kick_q <= 1'b0;
    end else begin
      sw_kick_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (awaddr_q)
          `SDFD_REG_WORD: begin
            if (wstrb_q[0]) sw_word_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) sw_word_q[15:8] <= wdata_q[15:8];
            if (wstrb_q[2]) sw_word_q[23:16] <= wdata_q[23:16];
            if (wstrb_q[3]) sw_word_q[31:24] <= wdata_q[31:24];
            sw_kick_q <= 1'b1;
          end
          `SDFD_REG_CTRL: begin
            if (wstrb_q[0]) ctrl_q <= wdata_q[4:0];
          end
          `SDFD_REG_FLAGS: begin
          end
          default: begin
            s_axi_bresp <= 2'h2;
          end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // AXI read: one cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  // Read-back of the fields, at the same bit positions as the word
  wire [31:0] fields_rd;
  wire [31:0] status_rd;
  assign fields_rd[`SDFD_MBZ_HI_MSB:`SDFD_MBZ_HI_LSB] = 6'h00;
  assign fields_rd[`SDFD_FLAG_HALF_BIT] = o_flag_half_select;
  assign fields_rd[`SDFD_VSTEP_MSB:`SDFD_VSTEP_LSB] =
    o_first_operand_vertical_step;
  assign fields_rd[`SDFD_MBZ_MID_BIT] = 1'b0;
  assign fields_rd[`SDFD_SWZ_MSB:`SDFD_SWZ_LSB] = o_first_operand_swizzle;
  assign fields_rd[`SDFD_ADDR_KIND_BIT] = o_first_operand_addressing_kind;
  assign fields_rd[`SDFD_MOD_MSB:`SDFD_MOD_LSB] = o_first_operand_modifier;
  assign fields_rd[`SDFD_REG_MSB:`SDFD_REG_LSB] =
    o_first_operand_register_index;
  assign fields_rd[`SDFD_HALF_OFS_BIT] = o_first_operand_half_offset;
  assign fields_rd[`SDFD_LANE_MSB:`SDFD_LANE_LSB] =
    o_first_operand_lane_enables;
  // Status: predicate mask, reserved-bit error, decode pulse
  assign status_rd = {14'h0000, o_pred_mask, o_must_be_zero_err,
    o_fields_valid};
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case ({s_axi_araddr[7:2], 2'b00})
        `SDFD_REG_WORD: s_axi_rdata <= sw_word_q;
        `SDFD_REG_CTRL: s_axi_rdata <= {27'h000_0000, ctrl_q};
        `SDFD_REG_FIELDS: s_axi_rdata <= fields_rd;
        `SDFD_REG_FLAGS: s_axi_rdata <= flags_all;
        `SDFD_REG_STATUS: s_axi_rdata <= status_rd;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // sdfd_top

// [sim/sdfd_fetch_model.sv]
`timescale 1ns/1ps
// Fetch stage stand-in, one word per request
module sdfd_fetch_model (
  // Request from the bench
  input logic i_clk,
  input logic i_go,
  input logic [31:0] i_word,
  input logic [2:0] i_mode,
  // Toward the decoder
  output logic o_valid,
  output logic [31:0] o_word,
  output logic [2:0] o_mode
);
  // Idle cycles show inverted stale values, never a held word
  initial {o_valid, o_word, o_mode} = '0;
  always @(posedge i_clk) begin
    o_valid <= i_go;
    o_word <= i_go ? i_word & 32'h03EF_FFFF : ~o_word;
    o_mode <= i_go ? i_mode : ~o_mode;
  end
endmodule // sdfd_fetch_model

// [sim/sdfd_top_sva.sv]
`timescale 1ns/1ps
// Decode and flag timing checks at the top ports
module sdfd_top_chk (
  // Clock and reset
  input logic i_clk,
  input logic i_rst_n,
  // Fetch and condition inputs
  input logic i_word_valid,
  input logic [31:0] i_third_instruction_word,
  input logic i_direct,
  input logic i_four_lane_aligned_access,
  input logic i_src_immediate,
  input logic i_pred_enable,
  input logic i_cond_enable,
  input logic i_cond_we,
  input logic [15:0] i_cond_flags,
  // Decoded outputs
  input logic o_fields_valid,
  input logic o_flag_half_select,
  input logic [3:0] o_first_operand_vertical_step,
  input logic [7:4] o_first_operand_swizzle,
  input logic o_first_operand_addressing_kind,
  input logic [1:0] o_first_operand_modifier,
  input logic [7:0] o_first_operand_register_index,
  input logic o_first_operand_half_offset,
  input logic [3:0] o_first_operand_lane_enables,
  input logic [15:0] o_pred_mask,
  // Register bus handshakes
  input logic s_axi_awready,
  input logic s_axi_wready,
  input logic s_axi_bvalid
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic quiet;
  logic take;
  logic opnd;
  logic [31:0] w;
  // Fetch word taken while no register write is in flight
  assign quiet = s_axi_awready & s_axi_wready & ~s_axi_bvalid;
  assign take = i_word_valid & i_direct & i_four_lane_aligned_access & quiet;
  assign opnd = take & ~i_src_immediate;
  assign w = i_third_instruction_word;
  a_decode_latency: assert property (take |=> o_fields_valid)
    else $error("decoded word not valid");
  a_flag_half: assert property (take |=>
    o_flag_half_select == $past(w[25])) else $error("bad flag half");
  a_vertical_step: assert property (opnd |=>
    o_first_operand_vertical_step == $past(w[24:21])) else $error("bad step");
  a_swizzle_bits: assert property (opnd |=>
    o_first_operand_swizzle == $past(w[19:16])) else $error("bad swizzle");
  a_kind_modifier: assert property (opnd |=>
    {o_first_operand_addressing_kind, o_first_operand_modifier}
    == $past(w[15:13])) else $error("bad kind or modifier");
  a_register_index: assert property (opnd |=>
    o_first_operand_register_index == $past(w[12:5])) else $error("bad reg");
  a_half_lanes: assert property (opnd |=>
    {o_first_operand_half_offset, o_first_operand_lane_enables}
    == $past(w[4:0])) else $error("bad half or lanes");
  a_immediate_zero: assert property (take & i_src_immediate |=>
    {o_first_operand_vertical_step, o_first_operand_swizzle,
    o_first_operand_addressing_kind, o_first_operand_modifier,
    o_first_operand_register_index, o_first_operand_half_offset,
    o_first_operand_lane_enables} == 24'h00_0000) else $error("imm fields");
  a_cond_to_pred: assert property (
    i_cond_we & i_cond_enable & i_pred_enable & quiet & ~take
    |=> !i_pred_enable || o_pred_mask == $past(i_cond_flags))
    else $error("flags not seen as predicate");
endmodule // sdfd_top_chk
bind sdfd_top sdfd_top_chk u_chk (.*);

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "sdfd_regs.vh"
// Self-checking bench for the third-word decoder
module tb_top;
  logic i_clk, i_rst_n, i_word_valid, i_direct, i_four_lane_aligned_access;
  logic i_src_immediate, i_pred_enable, i_cond_enable, i_cond_we, go;
  logic o_fields_valid, o_flag_half_select, o_first_operand_addressing_kind;
  logic o_first_operand_half_offset, o_must_be_zero_err;
  logic [1:0] o_first_operand_modifier, s_axi_bresp, s_axi_rresp, r;
  logic [2:0] mode, fm;
  logic [3:0] o_first_operand_vertical_step, o_first_operand_lane_enables;
  logic [3:0] s_axi_wstrb;
  logic [7:4] o_first_operand_swizzle;
  logic [7:0] o_first_operand_register_index, s_axi_awaddr, s_axi_araddr;
  logic [15:0] i_cond_flags, o_pred_mask;
  logic [31:0] i_third_instruction_word, s_axi_wdata, s_axi_rdata, d, wd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int fail_count, checked, cycles;
  // Design and fetch-side model
  sdfd_top uut (.*);
  sdfd_fetch_model u_fetch (.i_clk(i_clk), .i_go(go), .i_word(wd),
    .i_mode(mode), .o_valid(i_word_valid),
    .o_word(i_third_instruction_word), .o_mode(fm));
  assign {i_direct, i_four_lane_aligned_access, i_src_immediate} = fm;
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Hang guard
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge i_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) ||
      (s_axi_wvalid && !s_axi_wready));
    while (!s_axi_bvalid) @(posedge i_clk);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task axi_rd(input logic [7:0] a);
    @(posedge i_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge i_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge i_clk);
    s_axi_rready <= 1'b0;
    {d, r} = {s_axi_rdata, s_axi_rresp};
  endtask
  // One word from fetch; outputs settle two edges after the request
  task fetch(input logic [31:0] w, input logic [2:0] m);
    @(posedge i_clk);
    {go, wd, mode} <= {1'b1, w, m};
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  // Decoded outputs packed at the bit positions of the word
  function automatic logic [31:0] packed_fields();
    return {6'h0, o_flag_half_select, o_first_operand_vertical_step, 1'b0,
      o_first_operand_swizzle, o_first_operand_addressing_kind,
      o_first_operand_modifier, o_first_operand_register_index,
      o_first_operand_half_offset, o_first_operand_lane_enables};
  endfunction
  task t_regs;
    axi_rd(`SDFD_REG_CTRL);
    check("ctrl reset", d, {27'h0, `SDFD_RST_CTRL});
    axi_rd(`SDFD_REG_FLAGS);
    check("flags reset", d, `SDFD_RST_FLAGS);
    axi_rd(8'h40);
    check("bad read resp", {30'h0, r}, 32'h0000_0002);
    axi_wr(8'h40, 32'h1234_5678);
    check("bad write resp", {30'h0, r}, 32'h0000_0002);
    // Software word with reserved bits set, decoded on the kick
    axi_wr(`SDFD_REG_WORD, 32'hFFFF_FFFF);
    #1;
    check("kick valid", {31'h0, o_fields_valid}, 32'h1);
    check("kick fields", packed_fields(), 32'h03EF_FFFF);
    check("mbz flagged", {31'h0, o_must_be_zero_err}, 32'h1);
    axi_rd(`SDFD_REG_FIELDS);
    check("fields reg", d, 32'h03EF_FFFF);
    axi_rd(`SDFD_REG_STATUS);
    check("status reg", d, 32'h0003_FFFE);
    // Immediate operand from software control
    axi_wr(`SDFD_REG_CTRL, 32'h0000_001C);
    axi_wr(`SDFD_REG_WORD, 32'hFFFF_FFFF);
    #1;
    check("kick imm", packed_fields(), 32'h0200_0000);
  endtask
  task t_decode;
    logic [31:0] tab [5];
    logic [31:0] e;
    logic [31:0] s;
    tab = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h02AA_5555, 32'h0155_AAAA,
      32'h03FF_FFFF};
    // Back-to-back words, the last with an immediate operand
    for (int i = 0; i < 7; i++) begin
      @(posedge i_clk);
      {go, wd, mode} <= {i < 5, tab[i % 5], 2'b11, i == 4};
      #1;
      s = packed_fields();
      e = tab[(i + 3) % 5] & ((i == 6) ? 32'h0200_0000 : 32'h03EF_FFFF);
      if (i >= 2) begin
        check("valid", {31'h0, o_fields_valid}, 32'h1);
        check("high", s[25:16], e[25:16]);
        check("mid", s[15:5], e[15:5]);
        check("low", s[4:0], e[4:0]);
        check("mbz clear", {31'h0, o_must_be_zero_err}, 32'h0);
      end
    end
    // Other layouts leave the outputs alone
    for (int m = 0; m < 2; m++) begin
      fetch(32'h0155_AAAA, m ? 3'b100 : 3'b010);
      check("refused", {31'h0, o_fields_valid}, 32'h0);
      check("kept", {24'h0, o_first_operand_register_index}, 32'h0);
    end
  endtask
  task t_flags;
    fetch(32'h0200_0000, 3'b110);
    @(posedge i_clk);
    {i_pred_enable, i_cond_enable, i_cond_we} <= 3'h7;
    i_cond_flags <= 16'hA5C3;
    @(posedge i_clk);
    i_cond_we <= 1'b0;
    #1;
    check("mask one", {16'h0, o_pred_mask}, 32'hA5C3);
    // Dropped when the modifier is off
    @(posedge i_clk);
    {i_cond_enable, i_cond_we, i_cond_flags} <= {2'b01, 16'h0F0F};
    @(posedge i_clk);
    i_cond_we <= 1'b0;
    #1;
    check("mask kept", {16'h0, o_pred_mask}, 32'hA5C3);
    fetch(32'h0000_0000, 3'b110);
    check("mask zero", {16'h0, o_pred_mask}, 32'h0);
    axi_rd(`SDFD_REG_FLAGS);
    check("flag file", d, 32'hA5C3_0000);
    @(posedge i_clk);
    i_pred_enable <= 1'b0;
    #1;
    check("pred off", {16'h0, o_pred_mask}, 32'hFFFF);
  endtask
  // Main sequence
  initial begin
    {i_rst_n, go, wd, mode, i_pred_enable, i_cond_enable, i_cond_we} = '0;
    {i_cond_flags, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_wstrb} = 5'h0F;
    {fail_count, checked, cycles} = '0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_decode();
    t_flags();
    end_sim();
  end
endmodule // tb_top
